// >>> rtl/pswc_top.sv
/*
 * Power-state wake controller: full power, light sleep and deep sleep,
 * wake by a write to the test register, ready flag, wake status, event
 * pin and event interrupt flag, plus the two PHY power-down controls.
 * Assumes a register master on the plain strobe port, frame detectors
 * on the same clock, and a line-energy pin from the analog front end.
 */
// Chosen here: the strobed register port and the address map.
`default_nettype none
// Function
// - One full and two sleep states; sleep reads only control.
// - Sleep entry clears ready until wake completes.
// - Writes ignored until first read after reset/wake.
// - Test write in sleep wakes, selects full power.
// - Select 01 enters light sleep, gates clocks.
// - Light sleep enables frame detection automatically.
// - Frame in light sleep sets status 10, pin.
// - Any event sets interrupt flag regardless of pin.
// - Deep select stops MAC and host clocks.
// - Carrier in deep sleep sets status 01, pin.
// - Flag held while event active, then write-1-clear.
// - Pulse select gives 50ms pin, else level.
// - Pin drops on status, enable or pin-enable clear.
// - Wake status is readable.
// - General powerdown bit holds PHY down, resets on clear.
// - Energy powerdown bit powers PHY down without energy.
// - Energy return powers up, sets flag, interrupts.
// - Ready set within 2ms of wake write.
module pswc_top
    import pswc_pkg::*;
#(
    parameter int unsigned RESUME_CYCLES_P = RESUME_CYCLES,
    parameter int unsigned PULSE_CYCLES_P  = PULSE_CYCLES
) (
    input  wire logic          clk_sys,
    input  wire logic          reset_n,
    input  wire logic          ce,
    input  wire logic [7:0]    addr,
    input  wire logic [31:0]   wrData,
    input  wire logic          wrStrobe,
    input  wire logic          rdStrobe,
    output var  logic [31:0]   rdData,
    input  wire logic          wakeFrameSeen,
    input  wire logic          magicFrameSeen,
    input  wire logic          lineEnergyPin,
    output var  logic          powerEvent,
    output var  logic          hostIrq,
    output var  pswc_clk_t     clkGate,
    output var  pswc_phy_t     phyCtl
);
    typedef struct packed {
        pswc_state_t        state;
        logic               ready;
        logic               readSeen;
        logic               pinEn;
        logic               pulseSel;
        logic               wakeFrameEn;
        logic               energyWakeEn;
        logic [1:0]         wakeStatus;
        logic [1:0]         stateSel;
        logic               evtSts;
        logic               evtIrqEn;
        logic               genPd;
        logic               edPd;
        logic               edFlag;
        logic               edIrqEn;
        logic               energyPrev;
        logic               evtPrev;
        logic [CNT_W-1:0]   pulseCnt;
        logic [CNT_W-1:0]   waitCnt;
        logic               powerEvent;
        logic               hostIrq;
        logic               phyReset;
        logic               phyPowerDown;
        logic [31:0]        rdData;
        pswc_clk_t          clk;
    } pswc_core_st_t;

    localparam logic [CNT_W-1:0] RESUME_LAST = CNT_W'(RESUME_CYCLES_P - 1);
    localparam logic [CNT_W-1:0] PULSE_LAST  = CNT_W'(PULSE_CYCLES_P - 1);

    pswc_core_st_t q;
    pswc_core_st_t d;
    pswc_bus_req_t req;
    logic          energy;
    logic          sleeping;
    logic          wakeWrite;
    logic          wrOk;
    logic          evtInt;
    logic          evtRise;
    logic          energyRise;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    pswc_sync_in pswc_sync_in_i (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .ce       (ce),
        .pinIn    (lineEnergyPin),
        .levelOut (energy)
    );

    assign req = '{addr: addr, wrData: wrData, wrStrobe: wrStrobe, rdStrobe: rdStrobe};

    always_comb begin
        d            = q;
        d.rdData     = '0;
        d.phyReset   = 1'b0;
        sleeping     = (q.state == ST_LIGHT) || (q.state == ST_DEEP);
        wakeWrite    = req.wrStrobe && hit(req.addr, A_TEST) && sleeping;
        wrOk         = req.wrStrobe && q.readSeen && q.ready && (q.state == ST_FULL);
        evtInt       = (q.wakeStatus[1] && q.wakeFrameEn) || (q.wakeStatus[0] && q.energyWakeEn);
        evtRise      = evtInt && !q.evtPrev;
        energyRise   = energy && !q.energyPrev;
        d.evtPrev    = evtInt;
        d.energyPrev = energy;

        // register reads
        if (req.rdStrobe) begin
            d.readSeen = 1'b1;
            if (hit(req.addr, A_PMC)) begin
                d.rdData[PMC_READY]                = q.ready;
                d.rdData[PMC_PIN_EN]               = q.pinEn;
                d.rdData[PMC_PULSE]                = q.pulseSel;
                d.rdData[PMC_WS_LO+1:PMC_WS_LO]    = q.wakeStatus;
                d.rdData[PMC_WF_EN]                = q.wakeFrameEn;
                d.rdData[PMC_EW_EN]                = q.energyWakeEn;
                d.rdData[PMC_SEL_LO+1:PMC_SEL_LO]  = q.stateSel;
            end else if (q.ready && q.state == ST_FULL) begin
                if (hit(req.addr, A_INTERRUPT_STATUS_REGISTER)) begin
                    d.rdData[IS_EVENT] = q.evtSts;
                end else if (hit(req.addr, A_INT_EN)) begin
                    d.rdData[IS_EVENT] = q.evtIrqEn;
                end else if (hit(req.addr, A_TEST)) begin
                    d.rdData = TEST_PATTERN;
                end else if (hit(req.addr, A_PHY)) begin
                    d.rdData[PHY_GEN_PD]   = q.genPd;
                    d.rdData[PHY_ED_PD]    = q.edPd;
                    d.rdData[PHY_ED_FLAG]  = q.edFlag;
                    d.rdData[PHY_ED_IRQEN] = q.edIrqEn;
                end
            end
        end

        // register writes, clears before hardware sets
        if (wrOk && hit(req.addr, A_PMC)) begin
            d.pinEn        = req.wrData[PMC_PIN_EN];
            d.pulseSel     = req.wrData[PMC_PULSE];
            d.wakeFrameEn  = req.wrData[PMC_WF_EN];
            d.energyWakeEn = req.wrData[PMC_EW_EN];
            d.wakeStatus   = q.wakeStatus & ~req.wrData[PMC_WS_LO+1:PMC_WS_LO];
            d.stateSel     = req.wrData[PMC_SEL_LO+1:PMC_SEL_LO];
        end
        if (wrOk && hit(req.addr, A_INTERRUPT_STATUS_REGISTER) && req.wrData[IS_EVENT]) begin
            d.evtSts = 1'b0;
        end
        if (wrOk && hit(req.addr, A_INT_EN)) begin
            d.evtIrqEn = req.wrData[IS_EVENT];
        end
        if (wrOk && hit(req.addr, A_PHY)) begin
            d.genPd    = req.wrData[PHY_GEN_PD];
            d.edPd     = req.wrData[PHY_ED_PD];
            d.edIrqEn  = req.wrData[PHY_ED_IRQEN];
            if (req.wrData[PHY_ED_FLAG]) begin
                d.edFlag = 1'b0;
            end
            d.phyReset = q.genPd && !req.wrData[PHY_GEN_PD];
        end

        // power state sequencing
        unique case (q.state)
            ST_FULL: begin
                if (wrOk && hit(req.addr, A_PMC)) begin
                    if (req.wrData[PMC_SEL_LO+1:PMC_SEL_LO] == SEL_LIGHT) begin
                        d.state = ST_LIGHT;
                        d.ready = 1'b0;
                    end else if (req.wrData[PMC_SEL_LO+1:PMC_SEL_LO] == SEL_DEEP) begin
                        d.state = ST_DEEP;
                        d.ready = 1'b0;
                    end
                end
            end
            ST_LIGHT: begin
                if (wakeFrameSeen || magicFrameSeen) begin
                    d.wakeStatus = WS_FRAME;
                end
            end
            ST_DEEP: begin
                if (energy) begin
                    d.wakeStatus = q.wakeStatus | WS_ENERGY;
                end
            end
            ST_WAKE: begin
                if (q.waitCnt >= RESUME_LAST) begin
                    d.state    = ST_FULL;
                    d.ready    = 1'b1;
                    d.readSeen = 1'b0;
                end else begin
                    d.waitCnt = q.waitCnt + 1'b1;
                end
            end
        endcase
        if (wakeWrite) begin
            d.state    = ST_WAKE;
            d.stateSel = SEL_FULL;
            d.waitCnt  = '0;
            d.readSeen = 1'b0;
        end

        // event flag, pin and interrupt
        if (evtInt) begin
            d.evtSts = 1'b1;
        end
        if (!evtInt) begin
            d.pulseCnt = '0;
        end else if (evtRise) begin
            d.pulseCnt = PULSE_LAST;
        end else if (q.pulseCnt != '0) begin
            d.pulseCnt = q.pulseCnt - 1'b1;
        end
        d.powerEvent = q.pinEn && evtInt && (!q.pulseSel || evtRise || q.pulseCnt != '0);

        // phy power-down controls
        if (q.edPd && energyRise) begin
            d.edFlag = 1'b1;
        end
        d.phyPowerDown = d.genPd || (d.edPd && !energy);
        d.hostIrq      = (q.evtSts && q.evtIrqEn) || (q.edFlag && q.edIrqEn);

        // clock gating follows the next state
        d.clk.logicClkEn    = (d.state == ST_FULL) || (d.state == ST_WAKE);
        d.clk.macClkEn      = (d.state != ST_DEEP);
        d.clk.hostClkEn     = (d.state != ST_DEEP);
        d.clk.frameDetectEn = (d.state == ST_LIGHT);
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            q       <= '0;
            q.state <= ST_FULL;
            q.ready <= 1'b1;
            q.clk   <= '{logicClkEn: 1'b1, macClkEn: 1'b1, hostClkEn: 1'b1, frameDetectEn: 1'b0};
        end else if (ce) begin
            q <= d;
        end
    end

    assign rdData     = q.rdData;
    assign powerEvent = q.powerEvent;
    assign hostIrq    = q.hostIrq;
    assign clkGate    = q.clk;
    assign phyCtl     = '{powerDown: q.phyPowerDown, resetPulse: q.phyReset};

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    sleep_ready_a: assert property ((q.state == ST_LIGHT || q.state == ST_DEEP) |-> !q.ready)
        else $error("ready set while asleep");

    sleep_read_a: assert property (ce && rdStrobe && q.state != ST_FULL && addr != A_PMC |=> rdData == 32'h0)
        else $error("non-control read answered in sleep");

    wake_exit_a: assert property (ce && wakeWrite |=> q.state == ST_WAKE && q.stateSel == SEL_FULL && !q.ready)
        else $error("test write did not start wake");

    light_entry_a: assert property (ce && wrOk && addr == A_PMC && wrData[PMC_SEL_LO+1:PMC_SEL_LO] == SEL_LIGHT
                                    |=> q.state == ST_LIGHT && !q.clk.logicClkEn && q.clk.frameDetectEn)
        else $error("light sleep not entered");

    frame_status_a: assert property (ce && q.state == ST_LIGHT && wakeFrameSeen && !wakeWrite
                                     |=> q.wakeStatus == WS_FRAME)
        else $error("frame wake status not set");

    deep_status_a: assert property (ce && q.state == ST_DEEP && energy && !wakeWrite |=> q.wakeStatus[0])
        else $error("energy wake status not set");

    flag_hold_a: assert property (ce && evtInt |=> q.evtSts)
        else $error("event flag dropped while event active");

    pin_off_a: assert property (ce && (!evtInt || !q.pinEn) |=> !powerEvent)
        else $error("event pin active without cause");

    write_gate_a: assert property (ce && wrStrobe && !q.readSeen && addr == A_PMC && !wakeWrite
                                   |=> $stable(q.pinEn) && $stable(q.stateSel))
        else $error("write acted on before first read");

    ready_time_a: assert property (ce && q.state == ST_WAKE |-> q.waitCnt <= RESUME_LAST)
        else $error("resume wait overran");

    deep_entry_a: assert property (ce && wrOk && addr == A_PMC
                                   && wrData[PMC_SEL_LO+1:PMC_SEL_LO] == SEL_DEEP
                                   |=> q.state == ST_DEEP && !q.ready && !q.clk.macClkEn && !q.clk.hostClkEn)
        else $error("deep sleep not entered");

    wake_ready_a: assert property (ce && q.state == ST_WAKE && q.waitCnt >= RESUME_LAST
                                   |=> q.state == ST_FULL && q.ready && !q.readSeen)
        else $error("ready not restored after resume wait");

    phy_reset_a: assert property (ce && wrOk && addr == A_PHY && q.genPd && !wrData[PHY_GEN_PD]
                                  |=> phyCtl.resetPulse)
        else $error("phy reset pulse missing");

    powerdown_hold_a: assert property (ce && d.genPd |=> phyCtl.powerDown)
        else $error("phy not held down");

    ed_flag_a: assert property (ce && q.edPd && energyRise |=> q.edFlag)
        else $error("energy flag not set");

    pin_level_a: assert property (ce && q.pinEn && evtInt && !q.pulseSel |=> powerEvent)
        else $error("level event pin not driven");

    pulse_end_a: assert property (ce && q.pulseSel && !evtRise && q.pulseCnt == '0 |=> !powerEvent)
        else $error("event pulse overran");

    irq_raise_a: assert property (ce && q.evtSts && q.evtIrqEn |=> hostIrq)
        else $error("host interrupt not raised");
endmodule
`default_nettype wire

// >>> rtl/pswc_pkg.sv
/*
 * Shared constants and types of the power-state wake controller:
 * register offsets, field positions, encodings, timing counts and the
 * state type. Assumes a 10 MHz system clock and an 8-bit register address.
 */
`default_nettype none
package pswc_pkg;
    // register offsets
    localparam logic [7:0]  A_INTERRUPT_STATUS_REGISTER     = 8'h58;
    localparam logic [7:0]  A_INT_EN      = 8'h5C;
    localparam logic [7:0]  A_TEST        = 8'h64;
    localparam logic [7:0]  A_PMC         = 8'h84;
    localparam logic [7:0]  A_PHY         = 8'hA4;
    // power_mgmt_control fields
    localparam int          PMC_READY     = 0;
    localparam int          PMC_PIN_EN    = 1;
    localparam int          PMC_PULSE     = 3;
    localparam int          PMC_WS_LO     = 4;
    localparam int          PMC_WF_EN     = 8;
    localparam int          PMC_EW_EN     = 9;
    localparam int          PMC_SEL_LO    = 12;
    // interrupt_status_register / enable field
    localparam int          IS_EVENT      = 17;
    // phy control fields
    localparam int          PHY_GEN_PD    = 0;
    localparam int          PHY_ED_PD     = 1;
    localparam int          PHY_ED_FLAG   = 2;
    localparam int          PHY_ED_IRQEN  = 3;
    // encodings
    localparam logic [1:0]  SEL_FULL      = 2'h0;
    localparam logic [1:0]  SEL_LIGHT     = 2'h1;
    localparam logic [1:0]  SEL_DEEP      = 2'h2;
    localparam logic [1:0]  WS_FRAME      = 2'h2;
    localparam logic [1:0]  WS_ENERGY     = 2'h1;
    // test register read pattern, value arbitrary
    localparam logic [31:0] TEST_PATTERN  = 32'h5A5A_C3C3;
    // timing
    localparam int          CLK_PERIOD_NS = 100;
    localparam int          RESUME_TIME_US = 2000;
    localparam int          RESUME_CYCLES = RESUME_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int          PULSE_TIME_MS = 50;
    localparam int          PULSE_CYCLES  = PULSE_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int          CNT_W         = 20;

    typedef enum logic [1:0] {
        ST_FULL,
        ST_LIGHT,
        ST_DEEP,
        ST_WAKE
    } pswc_state_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wrData;
        logic        wrStrobe;
        logic        rdStrobe;
    } pswc_bus_req_t;

    typedef struct packed {
        logic        logicClkEn;
        logic        macClkEn;
        logic        hostClkEn;
        logic        frameDetectEn;
    } pswc_clk_t;

    typedef struct packed {
        logic        powerDown;
        logic        resetPulse;
    } pswc_phy_t;
endpackage
`default_nettype wire

// >>> rtl/pswc_sync_in.sv
/*
 * Three-stage input synchroniser for a pin from outside the clock domain.
 * The output level follows once the second and third stage agree.
 * Assumes the caller holds ce high for the stages to advance.
 */
`default_nettype none
module pswc_sync_in
    import pswc_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic reset_n,
    input  wire logic ce,
    input  wire logic pinIn,
    output var  logic levelOut
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } pswc_sync_st_t;

    pswc_sync_st_t q;
    pswc_sync_st_t d;

    always_comb begin
        d    = q;
        d.s1 = pinIn;
        d.s2 = q.s1;
        d.s3 = q.s2;
        if (q.s2 == q.s3) begin
            d.lvl = q.s3;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    assign levelOut = q.lvl;
endmodule
`default_nettype wire

// >>> tb/pswc_host_model.sv
/*
 * Host register master model for the power-state wake controller.
 * Assumes a free-running clk_sys and the plain strobe register port.
 */
`default_nettype none
module pswc_host_model
    import pswc_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic [31:0] rdData,
    output var  logic [7:0]  addr,
    output var  logic [31:0] wrData,
    output var  logic        wrStrobe,
    output var  logic        rdStrobe
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        addr     = 8'h00;
        wrData   = 32'h0;
        wrStrobe = 1'b0;
        rdStrobe = 1'b0;
    end

    // released bus shows inverted values, never the last ones
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr     <= a;
        wrData   <= d;
        wrStrobe <= 1'b1;
        @(posedge clk_sys);
        wrStrobe <= 1'b0;
        addr     <= ~a;
        wrData   <= ~d;
    endtask

    // data sampled once the taking edge has settled
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        addr     <= a;
        rdStrobe <= 1'b1;
        @(posedge clk_sys);
        rdStrobe <= 1'b0;
        addr     <= ~a;
        #1 d = rdData;
    endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
/*
 * Self-checking bench of the power-state wake controller.
 * Assumes the design package and a host model driving the register port.
 */
`default_nettype none
`define CHK(nm, got, exp) begin checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("BAD %s exp %h got %h", nm, exp, got); end end
module tb_top
    import pswc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int RESUME_P = 8;
    localparam int PULSE_P  = 6;

    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic ce = 1'b1;
    logic wakeFrameSeen = 1'b0;
    logic magicFrameSeen = 1'b0;
    logic lineEnergyPin = 1'b0;
    logic [7:0]  addr;
    logic [31:0] wrData;
    logic        wrStrobe;
    logic        rdStrobe;
    logic [31:0] rdData;
    logic        powerEvent;
    logic        hostIrq;
    pswc_clk_t   clkGate;
    pswc_phy_t   phyCtl;
    int          mismatches = 0;
    int          checks = 0;
    logic [31:0] seed = 32'hE0F8AD23;
    logic [31:0] v;
    int          n;

    always #50 clk_sys = ~clk_sys;

    pswc_host_model host_i (.clk_sys(clk_sys), .rdData(rdData), .addr(addr), .wrData(wrData),
        .wrStrobe(wrStrobe), .rdStrobe(rdStrobe));

    pswc_top #(.RESUME_CYCLES_P(RESUME_P), .PULSE_CYCLES_P(PULSE_P)) pswc_top_i (
        .clk_sys(clk_sys), .reset_n(reset_n), .ce(ce), .addr(addr), .wrData(wrData),
        .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .wakeFrameSeen(wakeFrameSeen),
        .magicFrameSeen(magicFrameSeen), .lineEnergyPin(lineEnergyPin), .powerEvent(powerEvent),
        .hostIrq(hostIrq), .clkGate(clkGate), .phyCtl(phyCtl));

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [31:0] exp_inten(input logic [31:0] d);
        return d & (32'h1 << IS_EVENT);
    endfunction

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic wake_and_poll();
        logic [31:0] r;
        time         t0;
        int          k;
        seed = lfsr_next(seed);
        host_i.wr(A_TEST, seed);
        t0 = $time;
        host_i.rd(A_PMC, r);
        `CHK("ready after wake", r[PMC_READY], 1'b0)
        `CHK("select after wake", r[13:12], SEL_FULL)
        k = 0;
        while (r[PMC_READY] !== 1'b1 && k < 40) begin
            host_i.rd(A_PMC, r);
            k++;
        end
        `CHK("ready in time", (($time - t0) / 100 <= RESUME_P + 4), 1'b1)
    endtask

    task automatic sleep_light(input bit magic);
        host_i.wr(A_PMC, 32'h0000_1102);
        repeat (2) @(posedge clk_sys);
        #1 `CHK("light gates", clkGate, pswc_clk_t'(4'h7))
        host_i.rd(A_PMC, v);
        `CHK("light control", v, 32'h0000_1102)
        host_i.rd(A_INT_EN, v);
        `CHK("sleep other read", v, 32'h0)
        @(posedge clk_sys);
        if (magic) magicFrameSeen <= 1'b1;
        else wakeFrameSeen <= 1'b1;
        @(posedge clk_sys);
        magicFrameSeen <= 1'b0;
        wakeFrameSeen  <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1 `CHK("event pin level", powerEvent, 1'b1)
        `CHK("host irq", hostIrq, 1'b1)
        host_i.rd(A_PMC, v);
        `CHK("frame status", v, 32'h0000_1122)
        wake_and_poll();
        host_i.rd(A_PMC, v);
        `CHK("awake control", v, 32'h0000_0123)
        host_i.rd(A_INTERRUPT_STATUS_REGISTER, v);
        `CHK("event flag", v, 32'h0002_0000)
        host_i.wr(A_INTERRUPT_STATUS_REGISTER, 32'h0002_0000);
        host_i.rd(A_INTERRUPT_STATUS_REGISTER, v);
        `CHK("flag held", v, 32'h0002_0000)
        host_i.wr(A_PMC, 32'h0000_0122);
        repeat (3) @(posedge clk_sys);
        #1 `CHK("pin drops", powerEvent, 1'b0)
        host_i.wr(A_INTERRUPT_STATUS_REGISTER, 32'h0002_0000);
        host_i.rd(A_INTERRUPT_STATUS_REGISTER, v);
        `CHK("flag cleared", v, 32'h0)
        `CHK("irq cleared", hostIrq, 1'b0)
        $display("light sleep test done, magic %0d", magic);
    endtask

    initial begin
        #(5000 * 100);
        mismatches++;
        print_verdict();
    end

    initial begin
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        #1 `CHK("reset gates", clkGate, pswc_clk_t'(4'hE))
        host_i.wr(A_PMC, 32'h0000_0002);
        host_i.rd(A_PMC, v);
        `CHK("write before read", v, 32'h0000_0001)
        host_i.rd(A_TEST, v);
        `CHK("test pattern", v, TEST_PATTERN)
        host_i.rd(8'h00, v);
        `CHK("unmapped read", v, 32'h0)
        for (int i = 0; i < 6; i++) begin
            seed = lfsr_next(seed);
            host_i.wr(A_INT_EN, seed);
            host_i.rd(A_INT_EN, v);
            `CHK("int enable", v, exp_inten(seed))
        end
        host_i.wr(A_INT_EN, 32'h0002_0000);
        $display("register test done");
        sleep_light(1'b0);
        sleep_light(1'b1);
        host_i.wr(A_PHY, 32'h0000_0002);
        repeat (2) @(posedge clk_sys);
        #1 `CHK("energy powerdown", phyCtl.powerDown, 1'b1)
        host_i.wr(A_PMC, 32'h0000_220A);
        repeat (2) @(posedge clk_sys);
        #1 `CHK("deep clocks", {clkGate.macClkEn, clkGate.hostClkEn}, 2'b00)
        host_i.rd(A_PMC, v);
        `CHK("deep control", v, 32'h0000_220A)
        @(posedge clk_sys);
        lineEnergyPin <= 1'b1;
        n = 0;
        repeat (30) begin
            @(posedge clk_sys);
            #1 n += int'(powerEvent === 1'b1);
        end
        `CHK("pulse length", n, PULSE_P)
        `CHK("phy powered up", phyCtl.powerDown, 1'b0)
        host_i.rd(A_PMC, v);
        `CHK("energy status", v, 32'h0000_221A)
        wake_and_poll();
        host_i.wr(A_PHY, 32'h0);
        host_i.rd(A_PHY, v);
        `CHK("energy flag", v, 32'h0000_0004)
        host_i.wr(A_INT_EN, 32'h0);
        host_i.wr(A_PHY, 32'h0000_0008);
        repeat (2) @(posedge clk_sys);
        #1 `CHK("energy irq", hostIrq, 1'b1)
        host_i.wr(A_PHY, 32'h0000_000C);
        repeat (2) @(posedge clk_sys);
        #1 `CHK("energy irq cleared", hostIrq, 1'b0)
        $display("deep sleep test done");
        host_i.wr(A_PHY, 32'h0000_0001);
        repeat (2) @(posedge clk_sys);
        #1 `CHK("general powerdown", phyCtl.powerDown, 1'b1)
        host_i.wr(A_PHY, 32'h0);
        n = 0;
        repeat (5) begin
            #1 n += int'(phyCtl.resetPulse === 1'b1);
            @(posedge clk_sys);
        end
        `CHK("phy reset pulse", n, 1)
        $display("phy powerdown test done");
        ce <= 1'b0;
        host_i.wr(A_INT_EN, 32'h0002_0000);
        ce <= 1'b1;
        host_i.rd(A_INT_EN, v);
        `CHK("frozen write", v, 32'h0)
        @(posedge clk_sys);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        host_i.wr(A_INT_EN, 32'h0002_0000);
        host_i.rd(A_INT_EN, v);
        `CHK("write after reset", v, 32'h0)
        $display("enable and reset test done");
        print_verdict();
    end
endmodule
`default_nettype wire
